// File: rtl/csa_pkg.sv
// package with constants for the common start/trip aggregator
package csa_pkg;
  localparam int CLK_HZ          = 100_000_000;
  localparam int TS_RES_US       = 1000;
  localparam int TS_TICK_CYC     = (CLK_HZ / 1_000_000) * TS_RES_US;
  localparam int TS_W            = 32;
  localparam int CNT_W           = 16;
  localparam int EV_CODE_W       = 2;
  localparam logic [1:0] FORCE_NORMAL = 2'h0;
  localparam logic [1:0] FORCE_START  = 2'h1;
  localparam logic [1:0] FORCE_TRIP   = 2'h2;
  localparam logic [1:0] COND_NORMAL  = 2'h0;
  localparam logic [1:0] COND_START   = 2'h1;
  localparam logic [1:0] COND_TRIP    = 2'h2;
  localparam logic [1:0] SEL_ON       = 2'h0;
  localparam logic [1:0] SEL_OFF      = 2'h1;
  localparam logic [1:0] SEL_BOTH     = 2'h2;
  localparam logic [1:0] EV_START_ON  = 2'h0;
  localparam logic [1:0] EV_START_OFF = 2'h1;
  localparam logic [1:0] EV_TRIP_ON   = 2'h2;
  localparam logic [1:0] EV_TRIP_OFF  = 2'h3;
endpackage

// File: rtl/csa_ms_timer.sv
// free-running millisecond time stamp
`timescale 1ns/1ps
module csa_ms_timer
  import csa_pkg::*;
#(
  parameter int TICK_CYC = TS_TICK_CYC
) (
  input  wire logic            core_clk,
  input  wire logic            rst,
  output logic [TS_W-1:0]      ms_count
);
  initial begin
    if (TICK_CYC < 1) $error("tick count must be at least one cycle");
  end

  logic [31:0] div_r;
  logic        tick;

  assign tick = (div_r == 32'(TICK_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_r <= 32'h0;
    end else if (tick) begin
      div_r <= 32'h0;
    end else begin
      div_r <= div_r + 32'h1;
    end
  end

  // one-cycle enable gives the 1 ms resolution
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ms_count <= '0;
    end else if (tick) begin
      ms_count <= ms_count + 1'b1;
    end
  end
endmodule // csa_ms_timer

// File: rtl/csa_edge_det.sv
// rising/falling edge detector for one level
`timescale 1ns/1ps
module csa_edge_det (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;
endmodule // csa_edge_det

// File: rtl/csa_common_signal_event_block.sv
// common start/trip aggregator with events, counters and force override
`timescale 1ns/1ps
module csa_common_signal_event_block
  import csa_pkg::*;
#(
  parameter int N_FUNC   = 8,
  parameter int N_EXTRA  = 4,
  parameter int PD_W     = 64,
  parameter int TICK_CYC = TS_TICK_CYC,
  parameter int EV_DEPTH = 4
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [N_FUNC-1:0]    func_active,
  input  wire logic [N_FUNC-1:0]    func_start,
  input  wire logic [N_FUNC-1:0]    func_trip,
  input  wire logic [N_EXTRA-1:0]   extra_start_in,
  input  wire logic [N_EXTRA-1:0]   extra_trip_in,
  input  wire logic                 stage_forcing_en,
  input  wire logic [1:0]           common_status_override,
  input  wire logic [1:0]           start_event_sel,
  input  wire logic [1:0]           trip_event_sel,
  input  wire logic                 counter_clear,
  input  wire logic [PD_W-1:0]      process_data,
  output logic                      common_start,
  output logic                      common_trip,
  output logic [1:0]                condition_code,
  output logic [CNT_W-1:0]          start_count,
  output logic [CNT_W-1:0]          trip_count,
  output logic                      event_valid,
  output logic [EV_CODE_W-1:0]      event_code,
  output logic [TS_W-1:0]           event_stamp,
  output logic [PD_W-1:0]           event_data
);
  initial begin
    if (N_FUNC < 1 || N_EXTRA < 1 || PD_W < 1) $error("widths must be at least one");
    if (EV_DEPTH < 2) $error("event queue needs at least two entries");
  end

  function automatic logic sel_keeps(input logic [1:0] sel, input logic is_on);
    sel_keeps = (sel == SEL_BOTH) || (is_on ? (sel == SEL_ON) : (sel == SEL_OFF));
  endfunction

  localparam int PTR_W  = (EV_DEPTH > 1) ? $clog2(EV_DEPTH) : 1;
  localparam int FILL_W = $clog2(EV_DEPTH + 1);

  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
    ptr_step = (p == PTR_W'(EV_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  logic [TS_W-1:0] ms_now;
  logic            start_raw;
  logic            trip_raw;
  logic            start_nxt;
  logic            trip_nxt;
  logic            start_rise;
  logic            start_fall;
  logic            trip_rise;
  logic            trip_fall;
  logic            force_on;

  csa_ms_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .ms_count (ms_now)
  );

  // no blocking input: inputs arrive already blocked upstream
  assign start_raw = |(func_start & func_active) | (|extra_start_in);
  assign trip_raw  = |(func_trip & func_active) | (|extra_trip_in);

  // force only counts while stage forcing is enabled; the setting is static
  assign force_on = stage_forcing_en && (common_status_override != FORCE_NORMAL);

  always_comb begin
    start_nxt = start_raw;
    trip_nxt  = trip_raw;
    if (force_on) begin
      start_nxt = (common_status_override == FORCE_START);
      trip_nxt  = (common_status_override == FORCE_TRIP);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      common_start <= 1'b0;
      common_trip  <= 1'b0;
    end else begin
      common_start <= start_nxt;
      common_trip  <= trip_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      condition_code <= COND_NORMAL;
    end else if (trip_nxt) begin
      condition_code <= COND_TRIP;
    end else if (start_nxt) begin
      condition_code <= COND_START;
    end else begin
      condition_code <= COND_NORMAL;
    end
  end

  csa_edge_det u_start_edge (
    .core_clk (core_clk),
    .rst      (rst),
    .level    (common_start),
    .rise     (start_rise),
    .fall     (start_fall)
  );

  csa_edge_det u_trip_edge (
    .core_clk (core_clk),
    .rst      (rst),
    .level    (common_trip),
    .rise     (trip_rise),
    .fall     (trip_fall)
  );

  // counters count ON transitions; a clear in the same cycle as an event loads one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_count <= '0;
    end else if (start_rise) begin
      start_count <= counter_clear ? CNT_W'(1) : start_count + 1'b1;
    end else if (counter_clear) begin
      start_count <= '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trip_count <= '0;
    end else if (trip_rise) begin
      trip_count <= counter_clear ? CNT_W'(1) : trip_count + 1'b1;
    end else if (counter_clear) begin
      trip_count <= '0;
    end
  end

  // both outputs may change in one cycle and inputs may keep toggling, so
  // events wait in a small queue instead of overwriting each other; the trip
  // event of a cycle goes ahead of its start event. a burst deeper than the
  // queue loses the start event of a colliding pair
  logic [EV_CODE_W-1:0] q_code_r  [EV_DEPTH];
  logic [TS_W-1:0]      q_stamp_r [EV_DEPTH];
  logic [PD_W-1:0]      q_data_r  [EV_DEPTH];
  logic [PTR_W-1:0]     q_head_r;
  logic [PTR_W-1:0]     q_tail_r;
  logic [FILL_W-1:0]    q_fill_r;
  logic                 q_empty;
  logic                 q_full;
  logic                 new_first;
  logic                 new_second;
  logic [EV_CODE_W-1:0] first_code;
  logic                 push_a;
  logic                 push_b;
  logic [EV_CODE_W-1:0] push_a_code;
  logic [PTR_W-1:0]     tail_b;
  logic                 start_ev;
  logic                 trip_ev;
  logic [EV_CODE_W-1:0] start_code;
  logic [EV_CODE_W-1:0] trip_code;

  assign start_ev   = (start_rise && sel_keeps(start_event_sel, 1'b1)) ||
                      (start_fall && sel_keeps(start_event_sel, 1'b0));
  assign trip_ev    = (trip_rise && sel_keeps(trip_event_sel, 1'b1)) ||
                      (trip_fall && sel_keeps(trip_event_sel, 1'b0));
  assign start_code = start_rise ? EV_START_ON : EV_START_OFF;
  assign trip_code  = trip_rise ? EV_TRIP_ON : EV_TRIP_OFF;

  assign q_empty     = (q_fill_r == '0);
  assign q_full      = (q_fill_r == FILL_W'(EV_DEPTH));
  assign new_first   = trip_ev || start_ev;
  assign new_second  = trip_ev && start_ev;
  assign first_code  = trip_ev ? trip_code : start_code;
  // an empty queue lets the first event bypass it, keeping latency at two cycles
  assign push_a      = q_empty ? new_second : new_first;
  assign push_a_code = q_empty ? start_code : first_code;
  // the pop always frees one slot; a second slot exists only below full
  assign push_b      = !q_empty && new_second && !q_full;
  assign tail_b      = ptr_step(q_tail_r);

  always_ff @(posedge core_clk) begin
    if (push_a) begin
      q_code_r[q_tail_r]  <= push_a_code;
      q_stamp_r[q_tail_r] <= ms_now;
      q_data_r[q_tail_r]  <= process_data;
    end
    if (push_b) begin
      q_code_r[tail_b]  <= start_code;
      q_stamp_r[tail_b] <= ms_now;
      q_data_r[tail_b]  <= process_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q_head_r <= '0;
      q_tail_r <= '0;
      q_fill_r <= '0;
    end else begin
      if (!q_empty) begin
        q_head_r <= ptr_step(q_head_r);
      end
      if (push_b) begin
        q_tail_r <= ptr_step(tail_b);
      end else if (push_a) begin
        q_tail_r <= tail_b;
      end
      q_fill_r <= q_fill_r - FILL_W'(!q_empty) + FILL_W'(push_a) + FILL_W'(push_b);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_valid <= 1'b0;
      event_code  <= EV_START_ON;
      event_stamp <= '0;
      event_data  <= '0;
    end else begin
      event_valid <= !q_empty || new_first;
      if (!q_empty) begin
        event_code  <= q_code_r[q_head_r];
        event_stamp <= q_stamp_r[q_head_r];
        event_data  <= q_data_r[q_head_r];
      end else if (new_first) begin
        event_code  <= first_code;
        event_stamp <= ms_now;
        event_data  <= process_data;
      end
    end
  end
endmodule // csa_common_signal_event_block

// File: testbench/csa_func_model.sv
// model of the protection function blocks feeding start and trip levels
`timescale 1ns/1ps
module csa_func_model #(
  parameter int N = 8
) (
  input  wire logic         core_clk,
  input  wire logic [N-1:0] act_cmd,
  input  wire logic [N-1:0] st_cmd,
  input  wire logic [N-1:0] tr_cmd,
  output logic      [N-1:0] func_active,
  output logic      [N-1:0] func_start,
  output logic      [N-1:0] func_trip
);
  initial {func_active, func_start, func_trip} = '0;
  // any trip blocking is already applied here, the block has no way to do it
  always @(posedge core_clk) begin
    #1;
    func_active <= act_cmd;
    func_start  <= st_cmd;
    func_trip   <= tr_cmd;
  end
endmodule // csa_func_model

// File: testbench/csa_chk.sv
// assertion checker for the common start/trip aggregator
`timescale 1ns/1ps
module csa_chk
  import csa_pkg::*;
#(
  parameter int N_FUNC  = 8,
  parameter int N_EXTRA = 4
) (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic [N_FUNC-1:0]  func_active,
  input wire logic [N_FUNC-1:0]  func_start,
  input wire logic [N_FUNC-1:0]  func_trip,
  input wire logic [N_EXTRA-1:0] extra_start_in,
  input wire logic [N_EXTRA-1:0] extra_trip_in,
  input wire logic               stage_forcing_en,
  input wire logic [1:0]         common_status_override,
  input wire logic [1:0]         trip_event_sel,
  input wire logic               counter_clear,
  input wire logic               common_start,
  input wire logic               common_trip,
  input wire logic [1:0]         condition_code,
  input wire logic [CNT_W-1:0]   trip_count,
  input wire logic               event_valid,
  input wire logic [1:0]         event_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire any_st = |(func_active & func_start) | (|extra_start_in);
  wire any_tr = |(func_active & func_trip) | (|extra_trip_in);
  sequence s_trip_rise;
    $rose(common_trip) && trip_event_sel == SEL_BOTH;
  endsequence
  sequence s_forced(logic [1:0] v);
    !$past(rst) && $past(stage_forcing_en) && $past(common_status_override) == v;
  endsequence
  a_start_or_in: assert property (!$past(rst) && !$past(stage_forcing_en) |-> common_start == $past(any_st))
    else $error("common start does not follow inputs");
  a_trip_or_in: assert property (!$past(rst) && !$past(stage_forcing_en) |-> common_trip == $past(any_tr))
    else $error("common trip does not follow inputs");
  a_cond_code: assert property (condition_code == (common_trip ? COND_TRIP : common_start ? COND_START : COND_NORMAL))
    else $error("condition code wrong");
  a_force_start: assert property (s_forced(FORCE_START) |-> common_start && !common_trip)
    else $error("forced start not applied");
  a_force_trip: assert property (s_forced(FORCE_TRIP) |-> common_trip && condition_code == COND_TRIP)
    else $error("forced trip not applied");
  a_trip_on_ev: assert property (s_trip_rise |=> event_valid && event_code == EV_TRIP_ON)
    else $error("trip on event missing");
  a_trip_off_ev: assert property ($fell(common_trip) && trip_event_sel == SEL_BOTH |=> event_valid && event_code == EV_TRIP_OFF)
    else $error("trip off event missing");
  a_trip_count: assert property ($rose(common_trip) && !counter_clear |=> trip_count == $past(trip_count) + 1'b1)
    else $error("trip counter did not step");
endmodule // csa_chk
bind csa_common_signal_event_block csa_chk #(.N_FUNC(N_FUNC), .N_EXTRA(N_EXTRA)) u_chk (.*);

// File: testbench/test_csa_common_signal_event_block.sv
// self-checking testbench for the common start/trip aggregator
`timescale 1ns/1ps
module test_csa_common_signal_event_block;
  import csa_pkg::*;
  logic             core_clk, rst, stage_forcing_en, counter_clear, common_start, common_trip, event_valid;
  logic [7:0]       act_cmd, st_cmd, tr_cmd, func_active, func_start, func_trip;
  logic [3:0]       extra_start_in, extra_trip_in;
  logic [1:0]       common_status_override, start_event_sel, trip_event_sel, condition_code, event_code;
  logic [63:0]      process_data, event_data;
  logic [CNT_W-1:0] start_count, trip_count;
  logic [TS_W-1:0]  event_stamp;
  int               failures, compares, ev_n;
  csa_func_model u_fm (.*);
  // short tick keeps the millisecond stamp moving within a short run
  csa_common_signal_event_block #(.TICK_CYC(10)) dut (.*);
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (event_valid === 1'b1) ev_n <= ev_n + 1;
  task go(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task final_report;
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task t_or;
    for (int i = 0; i < 8; i++) begin
      act_cmd = 8'h01 << i;
      st_cmd = 8'hFF;
      go(3);
      chk("start", common_start, 1);
      chk("cond", condition_code, COND_START);
      tr_cmd = ~act_cmd;
      go(3);
      chk("trip_inactive", common_trip, 0);
      tr_cmd = act_cmd;
      go(3);
      chk("cond_trip", condition_code, COND_TRIP);
      {st_cmd, tr_cmd} = 16'h0000;
      go(3);
    end
    for (int j = 0; j < 4; j++) begin
      extra_start_in = 4'h1 << j;
      go(2);
      chk("extra_start", common_start, 1);
      extra_start_in = 4'h0;
      extra_trip_in = 4'h1 << j;
      go(2);
      chk("extra_trip", common_trip, 1);
      extra_trip_in = 4'h0;
      go(2);
    end
  endtask
  task t_sel;
    for (int s = 0; s < 4; s++) begin
      start_event_sel = s[1:0];
      trip_event_sel = s[1:0];
      process_data = 64'hA5 + s;
      go(2);
      ev_n = 0;
      // both outputs change together, so trip and start events collide
      {extra_start_in, extra_trip_in} = 8'h11;
      go(5);
      {extra_start_in, extra_trip_in} = 8'h00;
      go(5);
      chk("event_count", ev_n, s == 3 ? 0 : s == 2 ? 4 : 2);
      if (s < 3) chk("last_code", event_code, s == 0 ? EV_START_ON : EV_START_OFF);
      if (s < 3) chk("snapshot", event_data[31:0], process_data[31:0]);
    end
  endtask
  task t_count;
    counter_clear = 1;
    go(2);
    counter_clear = 0;
    go(1);
    chk("clr", {start_count, trip_count}, 0);
    for (int k = 0; k < 3; k++) begin
      extra_trip_in = 4'h8;
      go(3);
      extra_trip_in = 4'h0;
      go(3);
    end
    chk("trip_cnt", trip_count, 3);
    chk("start_cnt", start_count, 0);
  endtask
  task t_force;
    stage_forcing_en = 1;
    common_status_override = FORCE_START;
    extra_trip_in = 4'h2;
    go(3);
    chk("f_start", {common_start, common_trip}, 2'b10);
    common_status_override = FORCE_TRIP;
    go(4);
    chk("f_trip", condition_code, COND_TRIP);
    chk("f_cnt", trip_count, 4);
    stage_forcing_en = 0;
    extra_trip_in = 4'h0;
    go(3);
    chk("f_off", common_trip, 0);
    stage_forcing_en = 1;
    common_status_override = FORCE_NORMAL;
    extra_start_in = 4'h4;
    go(3);
    chk("f_norm", common_start, 1);
    chk("f_scnt", start_count, 2);
  endtask
  task t_stamp;
    logic [TS_W-1:0] on_stamp;
    process_data = 64'h1234;
    extra_trip_in = 4'h1;
    go(3);
    on_stamp = event_stamp;
    chk("on_code", event_code, EV_TRIP_ON);
    chk("on_data", event_data[31:0], 32'h1234);
    // off edge lands 20 cycles after the on edge: two ticks of ten cycles
    go(17);
    process_data = 64'h5678;
    extra_trip_in = 4'h0;
    go(3);
    chk("off_code", event_code, EV_TRIP_OFF);
    chk("off_data", event_data[31:0], 32'h5678);
    chk("stamp_step", event_stamp - on_stamp, 2);
  endtask
  initial begin
    {rst, act_cmd, st_cmd, tr_cmd, extra_start_in, extra_trip_in} = 33'h100000000;
    {stage_forcing_en, counter_clear, common_status_override} = 4'h0;
    {start_event_sel, trip_event_sel, process_data} = {SEL_BOTH, SEL_BOTH, 64'h0};
    {failures, compares, ev_n} = '0;
    go(12);
    rst = 0;
    go(1);
    t_or;
    t_sel;
    trip_event_sel = SEL_BOTH;
    t_count;
    t_force;
    t_stamp;
    final_report;
  end
endmodule // test_csa_common_signal_event_block
